// ---- hdl/wmbus_framer_pkg.sv ----
`default_nettype none
package wmbus_framer_pkg;

    // ****************************************
    // modes and line codes
    // ****************************************
    typedef enum logic [2:0] {
        MODE_S = 3'b000,
        MODE_T = 3'b001,
        MODE_C = 3'b010,
        MODE_F = 3'b011,
        MODE_N = 3'b100,
        MODE_COMPACT_OTHER = 3'b101
    } wmbus_mode_t;

    typedef enum logic [1:0] {
        CODE_NRZ = 2'b00,
        CODE_MANCHESTER = 2'b01,
        CODE_3OF6 = 2'b10
    } line_code_t;

    // ****************************************
    // crc and block layout
    // ****************************************
    localparam logic [15:0] CRC_POLY = 16'h3D65;
    localparam logic [15:0] CRC_INIT = 16'h0000;
    localparam logic [15:0] CRC_XOR = 16'hFFFF;
    localparam logic [7:0] CRC_BYTES = 8'h02;
    localparam logic [7:0] A_FIRST_BLOCK = 8'h09;
    localparam logic [7:0] A_NEXT_BLOCK = 8'h10;
    localparam logic [7:0] B_FIRST_BLOCK = 8'h7D;
    localparam logic [7:0] B_NEXT_BLOCK = 8'hFF;

    // ****************************************
    // test payload
    // ****************************************
    localparam logic [7:0] C_FIELD = 8'h44;
    localparam logic [7:0] VERSION_FIELD = 8'h01;
    localparam logic [7:0] DEVICE_TYPE = 8'h07;
    localparam logic [7:0] CI_FIELD = 8'h78;
    localparam logic [7:0] DIF_FIELD = 8'h0B;
    localparam logic [7:0] VIF_FIELD = 8'h13;
    localparam logic [7:0] PAYLOAD_LEN = 8'h0F;
    localparam logic [3:0] IDX_LAST = 4'hE;
    localparam logic [7:0] LEN_A = PAYLOAD_LEN;
    localparam logic [7:0] LEN_B = 8'(PAYLOAD_LEN + CRC_BYTES
        + ((PAYLOAD_LEN > B_FIRST_BLOCK) ? CRC_BYTES : 8'h00));
    localparam int FIFO_DEPTH = 8;

endpackage
`default_nettype wire

// ---- hdl/wmbus_fifo.sv ----
`default_nettype none
module wmbus_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    logic do_write;
    logic do_read;

    // depth must be a power of two for the wrap bit to work
    assign out_valid = wr_ptr_reg != rd_ptr_reg;
    assign in_ready = (wr_ptr_reg[AW] == rd_ptr_reg[AW]) || (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]);
    assign out_data = mem_reg[rd_ptr_reg[AW-1:0]];
    assign do_write = clk_en && in_valid && in_ready;
    assign do_read = clk_en && out_valid && out_ready;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (do_write) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_read) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (do_write) begin
            mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end
endmodule
`default_nettype wire

// ---- hdl/wmbus_crc16.sv ----
`default_nettype none
module wmbus_crc16 (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic clear,
    input wire logic feed,
    input wire logic [7:0] data_in,
    output logic [15:0] crc_out
);
    import wmbus_framer_pkg::*;

    logic [15:0] crc_reg;
    logic [15:0] crc_base;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = (r[15] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    // clear and feed together restart the sum with this byte
    assign crc_base = clear ? CRC_INIT : crc_reg;
    assign crc_out = crc_reg ^ CRC_XOR;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_reg <= CRC_INIT;
        end else if (clk_en && feed) begin
            crc_reg <= crc_step(crc_base, data_in);
        end
    end
endmodule
`default_nettype wire

// ---- hdl/wmbus_framer.sv ----
// Notes on behaviour
// - S and T modes build Format A
// - Format A crc after 9, then 16
// - length byte always comes first
// - F, C, compact, N modes build Format B
// - Format B carries at most two crcs
// - Format B goes out NRZ only
// - Format B length counts crc bytes
// - Format B rx length from length byte
// - payload counter starts zero, steps per packet
// - crcs recomputed for every packet
// - good count only when all crcs match
// - identification bytes sent LSB first
// - compact mode is 2-GFSK 50 kbps NRZ
// - C receiver also takes T frames
// - T mode uses 3-of-6 coding
`default_nettype none
module wmbus_framer #(
    parameter logic [15:0] MANUF_ID = 16'hA5C3,   // value arbitrary
    parameter logic [31:0] METER_ID = 32'h0246_8ACE   // value arbitrary
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire wmbus_framer_pkg::wmbus_mode_t tx_mode,
    input wire logic tx_start,
    output logic [7:0] tx_byte,
    output logic tx_byte_valid,
    input wire logic tx_byte_ready,
    output wmbus_framer_pkg::line_code_t tx_line_code,
    output logic tx_gfsk2_50k,
    output logic tx_busy,
    output logic [23:0] tx_packet_count,
    input wire wmbus_framer_pkg::wmbus_mode_t rx_mode,
    input wire logic rx_frame_b,
    input wire logic [7:0] rx_byte,
    input wire logic rx_byte_valid,
    output logic [7:0] rx_length,
    output logic rx_done,
    output logic rx_crc_ok,
    output logic [15:0] rx_good_count
);
    import wmbus_framer_pkg::*;

    // ****************************************
    // transmit framing
    // ****************************************
    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_LEN = 3'b001,
        TX_DATA = 3'b010,
        TX_CRC_HI = 3'b011,
        TX_CRC_LO = 3'b100
    } tx_state_t;

    tx_state_t tx_state_reg;
    logic tx_fmt_b_reg;
    logic [7:0] len_byte_reg;
    logic [3:0] idx_reg;
    logic [7:0] tx_blk_reg;
    logic tx_first_reg;
    logic tx_fresh_reg;
    logic tx_done_data_reg;
    logic [1:0] crc_fields_reg;
    logic [23:0] pkt_cnt_reg;
    logic tx_busy_reg;
    line_code_t line_code_reg;
    logic gfsk_reg;
    logic [7:0] tx_byte_reg;
    logic tx_byte_valid_reg;

    logic [119:0] body;
    logic [7:0] push_data;
    logic push;
    logic fifo_in_ready;
    logic [7:0] fifo_out_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [15:0] tx_crc;
    logic [7:0] tx_limit;
    logic tx_block_end;
    logic tx_last;
    logic start_ok;
    logic start_fmt_b;

    // byte 0 goes out right after the length byte
    assign body = {pkt_cnt_reg[23:16], pkt_cnt_reg[15:8], pkt_cnt_reg[7:0],
        VIF_FIELD, DIF_FIELD, CI_FIELD, DEVICE_TYPE, VERSION_FIELD,
        METER_ID[31:24], METER_ID[23:16], METER_ID[15:8], METER_ID[7:0],
        MANUF_ID[15:8], MANUF_ID[7:0], C_FIELD};

    assign start_ok = (tx_state_reg == TX_IDLE) && tx_start;
    assign start_fmt_b = !(tx_mode == MODE_S || tx_mode == MODE_T);
    assign push = (tx_state_reg != TX_IDLE) && fifo_in_ready;
    assign tx_last = idx_reg == IDX_LAST;
    assign tx_limit = tx_first_reg ? (tx_fmt_b_reg ? B_FIRST_BLOCK : A_FIRST_BLOCK)
                                   : (tx_fmt_b_reg ? B_NEXT_BLOCK : A_NEXT_BLOCK);
    assign tx_block_end = tx_blk_reg == tx_limit - 8'h01;

    always_comb begin
        push_data = 8'h00;
        case (tx_state_reg)
            TX_LEN: push_data = len_byte_reg;
            TX_DATA: push_data = body[idx_reg*8 +: 8];
            TX_CRC_HI: push_data = tx_crc[15:8];
            TX_CRC_LO: push_data = tx_crc[7:0];
            default: push_data = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_state_reg <= TX_IDLE;
            tx_fmt_b_reg <= 1'b0;
            len_byte_reg <= 8'h00;
            idx_reg <= 4'h0;
            tx_blk_reg <= 8'h00;
            tx_first_reg <= 1'b1;
            tx_fresh_reg <= 1'b0;
            tx_done_data_reg <= 1'b0;
            crc_fields_reg <= 2'b00;
            tx_busy_reg <= 1'b0;
        end else if (clk_en) begin
            case (tx_state_reg)
                TX_IDLE: begin
                    if (start_ok) begin
                        tx_fmt_b_reg <= start_fmt_b;
                        len_byte_reg <= start_fmt_b ? LEN_B : LEN_A;
                        tx_busy_reg <= 1'b1;
                        tx_state_reg <= TX_LEN;
                    end
                end
                TX_LEN: begin
                    if (push) begin
                        idx_reg <= 4'h0;
                        tx_blk_reg <= 8'h00;
                        tx_first_reg <= 1'b1;
                        tx_fresh_reg <= 1'b0;
                        tx_done_data_reg <= 1'b0;
                        crc_fields_reg <= 2'b00;
                        tx_state_reg <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (push) begin
                        idx_reg <= idx_reg + 4'h1;
                        tx_blk_reg <= tx_blk_reg + 8'h01;
                        tx_fresh_reg <= 1'b0;
                        tx_done_data_reg <= tx_last;
                        if (tx_last || tx_block_end) begin
                            tx_state_reg <= TX_CRC_HI;
                        end
                    end
                end
                TX_CRC_HI: begin
                    if (push) begin
                        tx_state_reg <= TX_CRC_LO;
                    end
                end
                TX_CRC_LO: begin
                    if (push) begin
                        crc_fields_reg <= crc_fields_reg + 2'b01;
                        tx_blk_reg <= 8'h00;
                        tx_first_reg <= 1'b0;
                        tx_fresh_reg <= 1'b1;
                        if (tx_done_data_reg) begin
                            tx_busy_reg <= 1'b0;
                            tx_state_reg <= TX_IDLE;
                        end else begin
                            tx_state_reg <= TX_DATA;
                        end
                    end
                end
                default: tx_state_reg <= TX_IDLE;
            endcase
        end
    end

    // counter moves only once the last crc byte of the packet is pushed into the fifo
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pkt_cnt_reg <= 24'h000000;
        end else if (clk_en && push && tx_state_reg == TX_CRC_LO && tx_done_data_reg) begin
            pkt_cnt_reg <= pkt_cnt_reg + 24'h000001;
        end
    end

    // coding held for the whole packet, even if the mode input moves
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            line_code_reg <= CODE_NRZ;
            gfsk_reg <= 1'b0;
        end else if (clk_en && start_ok) begin
            if (tx_mode == MODE_S) begin
                line_code_reg <= CODE_MANCHESTER;
            end else if (tx_mode == MODE_T) begin
                line_code_reg <= CODE_3OF6;
            end else begin
                line_code_reg <= CODE_NRZ;
            end
            gfsk_reg <= tx_mode == MODE_COMPACT_OTHER;
        end
    end

    wmbus_crc16 u_tx_crc (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .clear(push && (tx_state_reg == TX_LEN || (tx_state_reg == TX_DATA && tx_fresh_reg))),
        .feed(push && (tx_state_reg == TX_LEN || tx_state_reg == TX_DATA)),
        .data_in(push_data),
        .crc_out(tx_crc)
    );

    wmbus_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .in_data(push_data),
        .in_valid(tx_state_reg != TX_IDLE),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready)
    );

    assign fifo_out_ready = !tx_byte_valid_reg || tx_byte_ready;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_byte_reg <= 8'h00;
            tx_byte_valid_reg <= 1'b0;
        end else if (clk_en && fifo_out_ready) begin
            tx_byte_valid_reg <= fifo_out_valid;
            if (fifo_out_valid) begin
                tx_byte_reg <= fifo_out_data;
            end
        end
    end

    assign tx_byte = tx_byte_reg;
    assign tx_byte_valid = tx_byte_valid_reg;
    assign tx_line_code = line_code_reg;
    assign tx_gfsk2_50k = gfsk_reg;
    assign tx_busy = tx_busy_reg;
    assign tx_packet_count = pkt_cnt_reg;

    // ****************************************
    // receive checking
    // ****************************************
    typedef enum logic [1:0] {
        RX_LEN = 2'b00,
        RX_DATA = 2'b01,
        RX_CRC_HI = 2'b10,
        RX_CRC_LO = 2'b11
    } rx_state_t;

    rx_state_t rx_state_reg;
    logic rx_fmt_b_reg;
    logic [7:0] rem_reg;
    logic [7:0] rx_blk_reg;
    logic rx_first_reg;
    logic rx_fresh_reg;
    logic rx_err_reg;
    logic [7:0] rx_length_reg;
    logic rx_done_reg;
    logic rx_ok_reg;
    logic [15:0] good_reg;
    logic [15:0] rx_crc;
    logic rx_is_b;
    logic [7:0] rx_rem_start;
    logic [7:0] rx_limit;
    logic lo_bad;

    // T frames reach a C receiver on their own sync word
    assign rx_is_b = (rx_mode == MODE_S || rx_mode == MODE_T) ? 1'b0 :
                     (rx_mode == MODE_C) ? rx_frame_b : 1'b1;
    assign rx_rem_start = !rx_is_b ? rx_byte :
        (rx_byte > B_FIRST_BLOCK + CRC_BYTES) ? 8'(rx_byte - CRC_BYTES - CRC_BYTES)
                                              : 8'(rx_byte - CRC_BYTES);
    assign rx_limit = rx_first_reg ? (rx_fmt_b_reg ? B_FIRST_BLOCK : A_FIRST_BLOCK)
                                   : (rx_fmt_b_reg ? B_NEXT_BLOCK : A_NEXT_BLOCK);
    assign lo_bad = rx_byte != rx_crc[7:0];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_state_reg <= RX_LEN;
            rx_fmt_b_reg <= 1'b0;
            rem_reg <= 8'h00;
            rx_blk_reg <= 8'h00;
            rx_first_reg <= 1'b1;
            rx_fresh_reg <= 1'b0;
            rx_err_reg <= 1'b0;
            rx_length_reg <= 8'h00;
            rx_done_reg <= 1'b0;
            rx_ok_reg <= 1'b0;
        end else if (clk_en) begin
            rx_done_reg <= 1'b0;
            rx_ok_reg <= 1'b0;
            if (rx_byte_valid) begin
                case (rx_state_reg)
                    RX_LEN: begin
                        rx_length_reg <= rx_byte;
                        rx_fmt_b_reg <= rx_is_b;
                        rem_reg <= rx_rem_start;
                        rx_blk_reg <= 8'h00;
                        rx_first_reg <= 1'b1;
                        rx_fresh_reg <= 1'b0;
                        rx_err_reg <= 1'b0;
                        // a length too short for any data is dropped as bad
                        if (rx_rem_start == 8'h00 || (rx_is_b && rx_byte <= CRC_BYTES)) begin
                            rx_done_reg <= 1'b1;
                        end else begin
                            rx_state_reg <= RX_DATA;
                        end
                    end
                    RX_DATA: begin
                        rem_reg <= rem_reg - 8'h01;
                        rx_blk_reg <= rx_blk_reg + 8'h01;
                        rx_fresh_reg <= 1'b0;
                        if (rem_reg == 8'h01 || rx_blk_reg == rx_limit - 8'h01) begin
                            rx_state_reg <= RX_CRC_HI;
                        end
                    end
                    RX_CRC_HI: begin
                        if (rx_byte != rx_crc[15:8]) begin
                            rx_err_reg <= 1'b1;
                        end
                        rx_state_reg <= RX_CRC_LO;
                    end
                    RX_CRC_LO: begin
                        rx_err_reg <= rx_err_reg || lo_bad;
                        rx_blk_reg <= 8'h00;
                        rx_first_reg <= 1'b0;
                        rx_fresh_reg <= 1'b1;
                        if (rem_reg == 8'h00) begin
                            rx_done_reg <= 1'b1;
                            rx_ok_reg <= !(rx_err_reg || lo_bad);
                            rx_state_reg <= RX_LEN;
                        end else begin
                            rx_state_reg <= RX_DATA;
                        end
                    end
                    default: rx_state_reg <= RX_LEN;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            good_reg <= 16'h0000;
        end else if (clk_en && rx_byte_valid && rx_state_reg == RX_CRC_LO
                     && rem_reg == 8'h00 && !(rx_err_reg || lo_bad)) begin
            good_reg <= good_reg + 16'h0001;
        end
    end

    wmbus_crc16 u_rx_crc (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .clear(rx_byte_valid && (rx_state_reg == RX_LEN || (rx_state_reg == RX_DATA && rx_fresh_reg))),
        .feed(rx_byte_valid && (rx_state_reg == RX_LEN || rx_state_reg == RX_DATA)),
        .data_in(rx_byte),
        .crc_out(rx_crc)
    );

    assign rx_length = rx_length_reg;
    assign rx_done = rx_done_reg;
    assign rx_crc_ok = rx_ok_reg;
    assign rx_good_count = good_reg;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_format_a_pick: assert property (clk_en && start_ok && !start_fmt_b |=> !tx_fmt_b_reg)
        else $error("S or T start did not pick Format A");
    a_format_b_pick: assert property (clk_en && start_ok && (tx_mode == MODE_F || tx_mode == MODE_N
        || tx_mode == MODE_C || tx_mode == MODE_COMPACT_OTHER) |=> tx_fmt_b_reg)
        else $error("Format B mode did not pick Format B");
    a_first_block_a: assert property (clk_en && push && tx_state_reg == TX_DATA && !tx_fmt_b_reg
        && tx_first_reg && idx_reg == 4'h8 |=> tx_state_reg == TX_CRC_HI)
        else $error("Format A first crc not after nine bytes");
    a_length_leads: assert property (clk_en && start_ok |=> tx_state_reg == TX_LEN ##0
        tx_state_reg == TX_LEN [*1])
        else $error("packet did not open with the length byte");
    a_crc_fields_b: assert property (tx_fmt_b_reg && tx_state_reg == TX_CRC_HI |->
        crc_fields_reg < 2'b10)
        else $error("Format B with more than two crc fields");
    a_nrz_format_b: assert property (tx_busy_reg && tx_fmt_b_reg |-> line_code_reg == CODE_NRZ)
        else $error("Format B packet not NRZ");
    a_length_value: assert property (push && tx_state_reg == TX_LEN |->
        push_data == (tx_fmt_b_reg ? LEN_B : LEN_A))
        else $error("length byte wrong for format");
    a_rx_len_b: assert property (clk_en && rx_byte_valid && rx_state_reg == RX_LEN && rx_is_b
        && rx_byte > CRC_BYTES && rx_byte <= B_FIRST_BLOCK + CRC_BYTES
        |=> rem_reg == $past(rx_byte) - CRC_BYTES)
        else $error("Format B receive length not taken from length byte");
    a_pkt_counter: assert property (clk_en && push && tx_state_reg == TX_CRC_LO && tx_done_data_reg
        |=> pkt_cnt_reg == $past(pkt_cnt_reg) + 24'h000001 && !tx_busy_reg)
        else $error("packet counter did not step at packet end");
    a_good_count: assert property (rx_done_reg |-> good_reg == $past(good_reg)
        + (rx_ok_reg ? 16'h0001 : 16'h0000))
        else $error("good count out of step with crc result");
    a_tmode_3of6: assert property (clk_en && start_ok && tx_mode == MODE_T |=>
        line_code_reg == CODE_3OF6 && !gfsk_reg)
        else $error("T mode not 3-of-6");
    a_compact_rate: assert property (clk_en && start_ok && tx_mode == MODE_COMPACT_OTHER |=>
        gfsk_reg && line_code_reg == CODE_NRZ)
        else $error("compact mode not 2-GFSK NRZ");

    c_tx_format_a: cover property (tx_busy_reg && !tx_fmt_b_reg && crc_fields_reg == 2'b10);
    c_tx_stall: cover property (tx_busy_reg && !fifo_in_ready);
    c_rx_good: cover property (rx_done_reg && rx_ok_reg);
    c_rx_bad: cover property (rx_done_reg && !rx_ok_reg);
endmodule
`default_nettype wire

// ---- verification/wmbus_peer.sv ----
`default_nettype none
module wmbus_peer (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic [7:0] tx_byte,
    input wire logic tx_byte_valid,
    output logic tx_byte_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] got[$];
    // ****************************************
    // radio side sink
    // ****************************************
    // slow peer drops ready every other cycle, so the fifo sees back-pressure
    initial begin
        tx_byte_ready = 1'b0;
        forever @(negedge core_clk) tx_byte_ready = !slow || !tx_byte_ready;
    end
    always @(posedge core_clk) begin
        if (rst_n && tx_byte_valid && tx_byte_ready) begin
            got.push_back(tx_byte);
        end
    end
endmodule
`default_nettype wire

// ---- verification/wmbus_framer_tb.sv ----
`default_nettype none
module wmbus_framer_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import wmbus_framer_pkg::*;
    localparam logic [15:0] MAN = 16'h2B4D; // value arbitrary
    localparam logic [31:0] SER = 32'h1357_9BDF; // value arbitrary
    logic core_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, tx_start = 1'b0, slow = 1'b0;
    wmbus_mode_t tx_mode = MODE_S, rx_mode = MODE_S;
    logic rx_frame_b = 1'b0, rx_byte_valid = 1'b0;
    logic [7:0] rx_byte = 8'h00, tx_byte, rx_length;
    logic tx_byte_valid, tx_byte_ready, tx_gfsk2_50k, tx_busy, rx_done, rx_crc_ok;
    line_code_t tx_line_code;
    logic [23:0] tx_packet_count;
    logic [15:0] rx_good_count, good = 16'h0000;
    int miscompares = 0, num_checks = 0;
    logic [7:0] exp[$];
    always #12.5 core_clk = ~core_clk;
    wmbus_framer #(.MANUF_ID(MAN), .METER_ID(SER)) DUT (.core_clk, .rst_n, .clk_en, .tx_mode,
        .tx_start, .tx_byte, .tx_byte_valid, .tx_byte_ready, .tx_line_code, .tx_gfsk2_50k,
        .tx_busy, .tx_packet_count, .rx_mode, .rx_frame_b, .rx_byte, .rx_byte_valid,
        .rx_length, .rx_done, .rx_crc_ok, .rx_good_count);
    wmbus_peer peer (.core_clk, .rst_n, .slow, .tx_byte, .tx_byte_valid, .tx_byte_ready);
    // ****************************************
    // reference frames
    // ****************************************
    function automatic logic [15:0] crc(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'h0000;
        foreach (q[i]) begin
            c = c ^ {q[i], 8'h00};
            for (int b = 0; b < 8; b++) c = c[15] ? ((c << 1) ^ 16'h3D65) : (c << 1);
        end
        return c ^ 16'hFFFF;
    endfunction
    task automatic frame(input logic fb, input logic [23:0] n);
        logic [7:0] body[$];
        logic [7:0] blk[$];
        logic [15:0] c;
        body = {C_FIELD, MAN[7:0], MAN[15:8], SER[7:0], SER[15:8], SER[23:16], SER[31:24],
            VERSION_FIELD, DEVICE_TYPE, CI_FIELD, DIF_FIELD, VIF_FIELD, n[7:0], n[15:8], n[23:16]};
        // format b length holds the one crc pair, format a only the data
        blk = fb ? {8'h11, body} : {8'h0F, body[0:8]};
        c = crc(blk);
        exp = {blk, c[15:8], c[7:0]};
        if (!fb) begin
            blk = body[9:14];
            c = crc(blk);
            exp = {exp, blk, c[15:8], c[7:0]};
        end
    endtask
    task automatic chk(input string what, input logic [23:0] e, input logic [23:0] s);
        num_checks++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, e, s);
        end
    endtask
    task automatic close_out;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic tx_all_modes;
        int k;
        for (int i = 0; i < 6; i++) begin
            peer.got.delete();
            slow = i[0];
            tx_mode = wmbus_mode_t'(i);
            tx_start = 1'b1;
            // start held over busy: the extra cycles must not frame a second packet
            repeat (3) @(negedge core_clk);
            chk("tx_busy", 1, tx_busy);
            tx_start = 1'b0;
            frame(i >= 2, 24'(i));
            for (k = 0; k < 400 && peer.got.size() < exp.size(); k++) @(negedge core_clk);
            repeat (12) @(negedge core_clk);
            chk("frame size", exp.size(), peer.got.size());
            if (k == 400) close_out();
            foreach (exp[j]) chk("tx byte", exp[j], peer.got[j]);
            chk("line code", (i == 0) ? CODE_MANCHESTER : (i == 1) ? CODE_3OF6 : CODE_NRZ,
                tx_line_code);
            chk("gfsk", i == 5, tx_gfsk2_50k);
            chk("packet count", i + 1, tx_packet_count);
            chk("tx_busy", 0, tx_busy);
        end
    endtask
    task automatic rx_one(input wmbus_mode_t m, input logic fb, input logic ok);
        int k;
        rx_mode = m;
        rx_frame_b = fb;
        frame(fb, 24'h000123);
        if (!ok) exp[3] = exp[3] ^ 8'h01;
        foreach (exp[i]) begin
            rx_byte = exp[i];
            rx_byte_valid = 1'b1;
            @(negedge core_clk);
        end
        rx_byte_valid = 1'b0;
        good = good + 16'(ok);
        for (k = 0; k < 8 && rx_done !== 1'b1; k++) @(negedge core_clk);
        chk("rx_done", 1, rx_done);
        if (k == 8) close_out();
        chk("rx_crc_ok", ok, rx_crc_ok);
        chk("rx_length", exp[0], rx_length);
        chk("rx_good_count", good, rx_good_count);
        repeat (2) @(negedge core_clk);
    endtask
    task automatic rx_all;
        rx_one(MODE_S, 1'b0, 1'b1);
        rx_one(MODE_S, 1'b0, 1'b0);
        rx_one(MODE_C, 1'b0, 1'b1);
        rx_one(MODE_C, 1'b1, 1'b1);
        rx_one(MODE_F, 1'b1, 1'b0);
    endtask
    initial begin
        repeat (8) @(negedge core_clk);
        chk("reset count", 0, tx_packet_count);
        rst_n = 1'b1;
        @(negedge core_clk);
        tx_all_modes();
        rx_all();
        close_out();
    end
endmodule
`default_nettype wire
